/* File: logic/irq_flags_pkg.sv */
// shared constants and types for the status flags and interrupt sequencer
package irq_flags_pkg;
    localparam int unsigned FLAG_C_POS        = 0;
    localparam int unsigned FLAG_Z_POS        = 1;
    localparam int unsigned FLAG_N_POS        = 2;
    localparam int unsigned FLAG_V_POS        = 3;
    localparam int unsigned FLAG_S_POS        = 4;
    localparam int unsigned FLAG_H_POS        = 5;
    localparam int unsigned FLAG_T_POS        = 6;
    localparam int unsigned FLAG_I_POS        = 7;
    localparam logic [7:0]  FLAGS_RESET       = 8'h00;
    localparam logic [1:0]  ADDR_FLAGS        = 2'h0;
    localparam logic [1:0]  ADDR_SEQ_STATUS   = 2'h1;
    localparam logic [1:0]  ADDR_IRQ_VECTOR   = 2'h2;
    localparam int unsigned NUM_SOURCES       = 8;
    localparam int unsigned ENTRY_CYCLES      = 4;
    localparam int unsigned WAKE_EXTRA_CYCLES = 4;
    localparam int unsigned JUMP_CYCLES       = 3;
    localparam int unsigned RETURN_CYCLES     = 4;
    localparam logic [3:0]  CNT_ZERO          = 4'h0;
    localparam logic [15:0] SP_RESET          = 16'h0000;

    // arithmetic result presented by the execution pipeline
    typedef struct packed {
        logic       valid;     // result with flag update this cycle
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       ovf;
        logic       upd_h;     // op affects half carry
        logic       upd_v;     // op affects overflow
        logic       upd_c;     // op affects carry
    } alu_flags_t;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [4:0] {
        ST_RUN    = 5'b00001,
        ST_WAKE   = 5'b00010,
        ST_ENTRY  = 5'b00100,
        ST_JUMP   = 5'b01000,
        ST_RETURN = 5'b10000
    } seq_state_t;
endpackage

/* File: logic/irq_arbiter.sv */
// picks the lowest numbered pending and locally enabled interrupt source
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter (
    input  wire logic [irq_flags_pkg::NUM_SOURCES-1:0] pending,
    input  wire logic [irq_flags_pkg::NUM_SOURCES-1:0] local_en,
    output logic                                       any_req,
    output logic [2:0]                                 req_id
);
    import irq_flags_pkg::*;

    logic [NUM_SOURCES-1:0] masked;

    // only sources with their own enable set may ask
    assign masked  = pending & local_en;
    assign any_req = |masked;

    // priority search, lowest index wins
    always_comb begin
        req_id = 3'h0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (masked[i]) begin
                req_id = 3'(i);
            end
        end
    end
endmodule // irq_arbiter
`default_nettype wire

/* File: logic/flag_calc.sv */
// derives the next arithmetic and logic flag values from a result
`timescale 1ns/1ps
`default_nettype none
module flag_calc (
    input  wire logic [7:0]                cur_flags,
    input  wire irq_flags_pkg::alu_flags_t alu,
    output logic [7:0]                     next_flags
);
    import irq_flags_pkg::*;

    logic n_bit;
    logic v_bit;
    logic z_bit;
    logic h_bit;
    logic c_bit;

    // flags follow the result; untouched flags keep their value
    assign n_bit = alu.result[7];                              // see RQ5
    assign z_bit = (alu.result == 8'h00);                      // see RQ6
    assign h_bit = alu.upd_h ? alu.half : cur_flags[FLAG_H_POS]; // see RQ2
    assign v_bit = alu.upd_v ? alu.ovf : cur_flags[FLAG_V_POS];  // see RQ4
    assign c_bit = alu.upd_c ? alu.carry : cur_flags[FLAG_C_POS]; // see RQ7

    // repack, sign is always n xor v
    always_comb begin
        next_flags             = cur_flags;
        next_flags[FLAG_C_POS] = c_bit;
        next_flags[FLAG_Z_POS] = z_bit;
        next_flags[FLAG_N_POS] = n_bit;
        next_flags[FLAG_V_POS] = v_bit;
        next_flags[FLAG_S_POS] = n_bit ^ v_bit;                // see RQ3
        next_flags[FLAG_H_POS] = h_bit;
    end
endmodule // flag_calc
`default_nettype wire

/* File: logic/irq_entry_flags.sv */
// status flag register and interrupt entry and return sequencer
// Notes on behaviour
// RQ1 - bit 6 receives a register bit on store, supplies it on load
// RQ2 - bit 5 set on carry out of the low nibble
// RQ3 - bit 4 always equals negative xor overflow
// RQ4 - bit 3 records signed two's complement overflow
// RQ5 - bit 2 set for a negative result
// RQ6 - bit 1 set for a zero result
// RQ7 - bit 0 set on carry
// RQ8 - one more instruction runs after global enable before any interrupt
// RQ9 - entry takes four cycles pushing the program counter, then vector
// RQ10 - the vector jump takes three cycles
// RQ11 - a multi-cycle instruction completes before entry begins
// RQ12 - wake from sleep adds four cycles after the mode's start-up time
// RQ13 - return takes four cycles, pops counter, sp plus two, sets enable
// RQ14 - service only with local enable and global enable both set
// RQ15 - entry clears the global enable until return sets it again
`timescale 1ns/1ps
`default_nettype none
module irq_entry_flags (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire irq_flags_pkg::reg_req_t               reg_req,
    output logic [7:0]                                 reg_rdata,
    input  wire irq_flags_pkg::alu_flags_t             alu,
    input  wire logic                                  instr_done,
    input  wire logic                                  exec_sei,
    input  wire logic                                  exec_cli,
    input  wire logic                                  exec_reti,
    input  wire logic                                  bit_store_instr,
    input  wire logic                                  bit_load_instr,
    input  wire logic [7:0]                            bit_src_reg,
    input  wire logic [2:0]                            bit_sel,
    input  wire logic                                  sleeping,
    input  wire logic                                  startup_done,
    input  wire logic [irq_flags_pkg::NUM_SOURCES-1:0] irq_pending,
    input  wire logic [irq_flags_pkg::NUM_SOURCES-1:0] irq_local_en,
    input  wire logic [15:0]                           pc_in,
    input  wire logic [15:0]                           stack_top,
    output logic [7:0]                                 bit_load_data,
    output logic [7:0]                                 cpu_status_flags,
    output logic                                       core_stall,
    output logic                                       push_valid,
    output logic [15:0]                                push_pc,
    output logic                                       pc_load,
    output logic [15:0]                                pc_load_value,
    output logic [15:0]                                sp_out,
    output logic                                       irq_ack,
    output logic [2:0]                                 irq_ack_id,
    output logic                                       in_handler
);
    import irq_flags_pkg::*;

    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  alu_next;
    seq_state_t  state_reg;
    seq_state_t  state_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic        sei_shadow_reg;
    logic        sei_shadow_next;
    logic        nest_reg;
    logic        nest_next;
    logic [2:0]  id_reg;
    logic [15:0] sp_reg;
    logic [15:0] sp_next;
    logic [15:0] ret_pc_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  load_reg;
    logic        ack_reg;
    logic        push_reg;
    logic        pcl_reg;
    logic [15:0] pcl_val_reg;
    logic        any_req;
    logic [2:0]  req_id;
    logic        take_irq;
    logic        gie;
    logic        flags_wr;
    logic        t_next;
    logic [7:0]  seq_status;

    irq_arbiter u_arb (
        .pending  (irq_pending),
        .local_en (irq_local_en),
        .any_req  (any_req),
        .req_id   (req_id)
    );

    flag_calc u_flags (
        .cur_flags  (flags_reg),
        .alu        (alu),
        .next_flags (alu_next)
    );

    // decode of the register port and service condition
    assign gie        = flags_reg[FLAG_I_POS];
    assign flags_wr   = reg_req.wr && (reg_req.addr == ADDR_FLAGS);
    // the instruction after the enable may finish and hand over to entry
    assign take_irq   = any_req && gie
                     && (!sei_shadow_reg || instr_done);    // see RQ14, RQ8
    assign t_next     = bit_src_reg[bit_sel];               // see RQ1
    assign seq_status = {3'h0, state_reg == ST_RUN ? 1'b0 : 1'b1,
                         nest_reg, id_reg};

    // flag register next value, highest priority last
    always_comb begin
        flags_next = flags_reg;
        if (alu.valid) begin
            flags_next = alu_next;
        end
        if (bit_store_instr) begin
            flags_next[FLAG_T_POS] = t_next;                // see RQ1
        end
        if (exec_sei) begin
            flags_next[FLAG_I_POS] = 1'b1;
        end
        if (exec_cli) begin
            flags_next[FLAG_I_POS] = 1'b0;
        end
        if (flags_wr) begin
            flags_next = reg_req.wdata;
            flags_next[FLAG_S_POS] = reg_req.wdata[FLAG_N_POS]
                                   ^ reg_req.wdata[FLAG_V_POS]; // see RQ3
        end
        if (state_reg == ST_ENTRY && cnt_reg == CNT_ZERO) begin
            flags_next[FLAG_I_POS] = 1'b0;                  // see RQ15
        end
        if (state_reg == ST_RETURN &&
            cnt_reg == 4'(RETURN_CYCLES - 1)) begin
            flags_next[FLAG_I_POS] = 1'b1;                  // see RQ13
        end
    end

    // sequencer: run, wake, entry, vector jump, return
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg + 4'h1;
        sp_next         = sp_reg;
        nest_next       = nest_reg;
        sei_shadow_next = sei_shadow_reg;
        if (exec_sei && !gie) begin
            sei_shadow_next = 1'b1;                         // see RQ8
        end else if (instr_done) begin
            sei_shadow_next = 1'b0;
        end
        case (state_reg)
            ST_RUN: begin
                cnt_next = CNT_ZERO;
                if (sleeping && take_irq && startup_done) begin
                    state_next = ST_WAKE;                   // see RQ12
                end else if (!sleeping && take_irq && instr_done) begin
                    state_next = ST_ENTRY;                  // see RQ11
                end else if (exec_reti && instr_done) begin
                    state_next = ST_RETURN;
                end
            end
            ST_WAKE: begin
                if (cnt_reg == 4'(WAKE_EXTRA_CYCLES - 1)) begin
                    state_next = ST_ENTRY;                  // see RQ12
                    cnt_next   = CNT_ZERO;
                end
            end
            ST_ENTRY: begin
                if (cnt_reg == CNT_ZERO) begin
                    sp_next = sp_reg - 16'h0002;            // see RQ9
                end
                if (cnt_reg == 4'(ENTRY_CYCLES - 1)) begin
                    state_next = ST_JUMP;                   // see RQ9
                    cnt_next   = CNT_ZERO;
                    nest_next  = 1'b1;
                end
            end
            ST_JUMP: begin
                if (cnt_reg == 4'(JUMP_CYCLES - 1)) begin
                    state_next = ST_RUN;                    // see RQ10
                    cnt_next   = CNT_ZERO;
                end
            end
            ST_RETURN: begin
                if (cnt_reg == CNT_ZERO) begin
                    sp_next = sp_reg + 16'h0002;            // see RQ13
                end
                if (cnt_reg == 4'(RETURN_CYCLES - 1)) begin
                    state_next = ST_RUN;                    // see RQ13
                    cnt_next   = CNT_ZERO;
                    nest_next  = 1'b0;
                end
            end
            default: begin
                state_next = ST_RUN;
                cnt_next   = CNT_ZERO;
            end
        endcase
    end

    // state and flag registers
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg      <= FLAGS_RESET;
            state_reg      <= ST_RUN;
            cnt_reg        <= CNT_ZERO;
            sei_shadow_reg <= 1'b0;
            nest_reg       <= 1'b0;
            sp_reg         <= SP_RESET;
        end else begin
            flags_reg      <= flags_next;
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            sei_shadow_reg <= sei_shadow_next;
            nest_reg       <= nest_next;
            sp_reg         <= sp_next;
        end
    end

    // captured identity, return address and one-cycle strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            id_reg      <= 3'h0;
            ret_pc_reg  <= 16'h0000;
            ack_reg     <= 1'b0;
            push_reg    <= 1'b0;
            pcl_reg     <= 1'b0;
            pcl_val_reg <= 16'h0000;
        end else begin
            ack_reg  <= (state_reg != ST_ENTRY) && (state_next == ST_ENTRY);
            push_reg <= (state_reg == ST_ENTRY) && (cnt_reg == CNT_ZERO);
            pcl_reg  <= 1'b0;
            if ((state_reg != ST_ENTRY) && (state_next == ST_ENTRY)) begin
                id_reg     <= req_id;
                ret_pc_reg <= pc_in;                        // see RQ9
            end
            if (state_reg == ST_ENTRY &&
                cnt_reg == 4'(ENTRY_CYCLES - 1)) begin
                pcl_reg     <= 1'b1;                        // see RQ9
                pcl_val_reg <= {12'h000, id_reg, 1'b0};
            end
            if (state_reg == ST_RETURN &&
                cnt_reg == 4'(RETURN_CYCLES - 1)) begin
                pcl_reg     <= 1'b1;                        // see RQ13
                pcl_val_reg <= stack_top;
            end
        end
    end

    // register read port and bit-load data, both one cycle late
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            load_reg  <= 8'h00;
        end else begin
            rdata_reg <= 8'h00;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    ADDR_FLAGS:      rdata_reg <= flags_reg;
                    ADDR_SEQ_STATUS: rdata_reg <= seq_status;
                    ADDR_IRQ_VECTOR: rdata_reg <= {5'h00, id_reg};
                    default:         rdata_reg <= 8'h00;
                endcase
            end
            if (bit_load_instr) begin
                load_reg          <= bit_src_reg;
                load_reg[bit_sel] <= flags_reg[FLAG_T_POS]; // see RQ1
            end
        end
    end

    assign reg_rdata        = rdata_reg;
    assign bit_load_data    = load_reg;
    assign cpu_status_flags = flags_reg;
    assign core_stall       = (state_reg != ST_RUN);
    assign push_valid       = push_reg;
    assign push_pc          = ret_pc_reg;
    assign pc_load          = pcl_reg;
    assign pc_load_value    = pcl_val_reg;
    assign sp_out           = sp_reg;
    assign irq_ack          = ack_reg;
    assign irq_ack_id       = id_reg;
    assign in_handler       = nest_reg;
endmodule // irq_entry_flags
`default_nettype wire

/* File: verification/irq_flags_checker_assertions.sv */
// port assertions for the flag register and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module irq_flags_checker
    import irq_flags_pkg::*;
(
    input wire logic                                  clk,
    input wire logic                                  rst,
    input wire logic                                  irq_ack,
    input wire logic [2:0]                            irq_ack_id,
    input wire logic                                  push_valid,
    input wire logic                                  pc_load,
    input wire logic [15:0]                           pc_load_value,
    input wire logic                                  core_stall,
    input wire logic [7:0]                            cpu_status_flags,
    input wire logic [15:0]                           sp_out,
    input wire logic                                  sleeping,
    input wire logic                                  exec_reti,
    input wire logic                                  instr_done,
    input wire logic [irq_flags_pkg::NUM_SOURCES-1:0] irq_pending,
    input wire logic [irq_flags_pkg::NUM_SOURCES-1:0] irq_local_en,
    input wire logic                                  bit_store_instr,
    input wire logic [7:0]                            bit_src_reg,
    input wire logic [2:0]                            bit_sel
);
    wire logic [7:0] f = cpu_status_flags;
    wire logic       ret_go = exec_reti && instr_done && !core_stall;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sign_xor: assert property (
        f[4] == (f[2] ^ f[3]))
        else $error("sign flag is not negative xor overflow");
    a_bit_store: assert property (
        bit_store_instr |=> f[6] == |(($past(bit_src_reg)
            >> $past(bit_sel)) & 8'h01))
        else $error("copy flag did not take the register bit");
    a_ack_push: assert property (
        irq_ack |=> push_valid && sp_out == $past(sp_out) - 16'h2)
        else $error("return address push missing after ack");
    a_entry_len: assert property (
        irq_ack && !sleeping |-> ##4 (pc_load
            && pc_load_value == {12'h000, $past(irq_ack_id, 4), 1'b0}))
        else $error("vector load not four cycles after ack");
    a_wake_len: assert property (
        irq_ack && sleeping |-> $past(core_stall, 4)
            && !$past(core_stall, 5) ##4 pc_load)
        else $error("wake entry not four cycles longer");
    a_jump_len: assert property (
        pc_load && core_stall |-> core_stall[*3] ##1 !core_stall)
        else $error("vector jump not three cycles");
    a_gate_enable: assert property (
        irq_ack |-> $past(f[7]) && $past(|(irq_pending & irq_local_en)))
        else $error("interrupt taken without both enables");
    a_entry_clr_i: assert property (
        push_valid |-> !f[7])
        else $error("global enable still set during entry");
    a_ret_len: assert property (
        ret_go |=> core_stall[*4] ##1 (pc_load && !core_stall && f[7]))
        else $error("return not four cycles or enable not set");
    a_ret_sp: assert property (
        ret_go |-> ##2 sp_out == $past(sp_out, 2) + 16'h2)
        else $error("stack pointer not raised by two on return");
endmodule // irq_flags_checker

bind irq_entry_flags irq_flags_checker u_chk (.clk, .rst, .irq_ack,
    .irq_ack_id, .push_valid, .pc_load, .pc_load_value, .core_stall,
    .cpu_status_flags, .sp_out, .sleeping, .exec_reti, .instr_done,
    .irq_pending, .irq_local_en, .bit_store_instr, .bit_src_reg, .bit_sel);
`default_nettype wire

/* File: verification/pipe_src_model.sv */
// far side model: instruction pipeline and peripheral interrupt sources
`timescale 1ns/1ps
`default_nettype none
module pipe_src_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       core_stall,
    input  wire logic       multi,       // instructions take three cycles
    input  wire logic [2:0] op,          // queue {reti, cli, sei}
    input  wire logic [7:0] raise,       // one pulse per source
    input  wire logic       irq_ack,
    input  wire logic [2:0] irq_ack_id,
    output logic            instr_done,
    output logic            exec_sei,
    output logic            exec_cli,
    output logic            exec_reti,
    output logic [7:0]      irq_pending
);
    logic [1:0] cnt_reg;
    logic [2:0] op_reg;
    logic [7:0] ack_mask;
    // an instruction ends when its cycles are used and the core runs
    assign instr_done = !core_stall && cnt_reg == (multi ? 2'h2 : 2'h0);
    assign {exec_reti, exec_cli, exec_sei} = op_reg & {3{instr_done}};
    assign ack_mask = irq_ack ? 8'h01 << irq_ack_id : 8'h00;
    // count cycles, queue ops, hold each flag until acknowledged
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg     <= 2'h0;
            op_reg      <= 3'h0;
            irq_pending <= 8'h00;
        end else begin
            cnt_reg     <= instr_done ? 2'h0 : cnt_reg + {1'b0, !core_stall};
            op_reg      <= (instr_done ? 3'h0 : op_reg) | op;
            irq_pending <= (irq_pending | raise) & ~ack_mask;
        end
    end
endmodule // pipe_src_model
`default_nettype wire

/* File: verification/irq_entry_flags_tb.sv */
// testbench: flags, bit copy, interrupt entry, return and wake
`timescale 1ns/1ps
`default_nettype none
module irq_entry_flags_tb;
    import irq_flags_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, multi = 1'b0, prev_done;
    reg_req_t    reg_req = '0;
    alu_flags_t  alu = '0, a;
    logic        bit_store_instr = 1'b0, bit_load_instr = 1'b0;
    logic [7:0]  bit_src_reg = 8'h00, irq_local_en = 8'hf7, raise = 8'h00;
    logic [2:0]  bit_sel = 3'h0, op = 3'h0, irq_ack_id;
    logic        sleeping = 1'b0, startup_done = 1'b0;
    logic [15:0] pc_in = 16'h0abc, stack_top = 16'h1234;
    logic [7:0]  reg_rdata, bit_load_data, cpu_status_flags, irq_pending;
    logic [15:0] push_pc, pc_load_value, sp_out;
    logic        instr_done, exec_sei, exec_cli, exec_reti, core_stall;
    logic        push_valid, pc_load, irq_ack, in_handler;
    int          n_fail = 0, n_compared = 0, n;
    wire logic [4:0] ev = {exec_cli, exec_sei, exec_reti, pc_load, irq_ack};

    irq_entry_flags u_dut (.clk, .rst, .reg_req, .reg_rdata, .alu,
        .instr_done, .exec_sei, .exec_cli, .exec_reti, .bit_store_instr,
        .bit_load_instr, .bit_src_reg, .bit_sel, .sleeping, .startup_done,
        .irq_pending, .irq_local_en, .pc_in, .stack_top, .bit_load_data,
        .cpu_status_flags, .core_stall, .push_valid, .push_pc, .pc_load,
        .pc_load_value, .sp_out, .irq_ack, .irq_ack_id, .in_handler);
    pipe_src_model u_far (.clk, .rst, .core_stall, .multi, .op, .raise,
        .irq_ack, .irq_ack_id, .instr_done, .exec_sei, .exec_cli,
        .exec_reti, .irq_pending);

    always #4 clk = ~clk;
    // remember whether an instruction completed in the last cycle
    always @(posedge clk) begin
        prev_done <= instr_done;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic reg_wr(input logic [1:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, ad, d};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic reg_rd(input logic [1:0] ad, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge clk);
        reg_req <= '0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic issue(input logic [2:0] o, input logic [7:0] r);
        @(posedge clk);
        op <= o;
        raise <= r;
    endtask
    // count edges until the chosen event shows, bounded
    task automatic wait_for(input int sel, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            op <= 3'h0;    // op and raise are one-cycle pulses
            raise <= 8'h00;
            #1;
            cnt++;
            if (cnt > 200) begin
                $display("mismatch at %0t: event %0d never came", $time, sel);
                n_fail++;
                close_out;
            end
        end while (ev[sel] !== 1'b1);
    endtask
    task automatic quiet(input int k);
        repeat (k) begin
            @(posedge clk);
            op <= 3'h0;
            raise <= 8'h00;
            #1;
            check(irq_ack, 1'b0);
        end
    endtask
    function automatic logic [7:0] fl(input logic [7:0] o, alu_flags_t x);
        logic [7:0] r;
        r = o;
        r[1] = x.result == 8'h00;
        r[2] = x.result[7];
        if (x.upd_h) r[5] = x.half;
        if (x.upd_v) r[3] = x.ovf;
        if (x.upd_c) r[0] = x.carry;
        r[4] = r[2] ^ r[3];
        return r;
    endfunction

    initial begin
        logic [7:0] exp, res [4];
        res = '{8'h00, 8'h80, 8'h7f, 8'hff};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_rd(ADDR_FLAGS, FLAGS_RESET);
        reg_wr(2'h3, 8'hff);
        reg_rd(2'h3, 8'h00);
        reg_wr(ADDR_FLAGS, 8'h04);
        reg_rd(ADDR_FLAGS, 8'h14);
        reg_wr(ADDR_FLAGS, 8'h08);
        reg_rd(ADDR_FLAGS, 8'h18);
        reg_wr(ADDR_FLAGS, 8'h00);
        exp = 8'h00;
        for (int i = 0; i < 4; i++) begin
            a = '{1'b1, res[i], i[0], i[1], i[0] ^ i[1], 1'b1, i != 2, 1'b1};
            exp = fl(exp, a);
            @(posedge clk);
            alu <= a;
            @(posedge clk);
            alu <= '0;
            #1;
            check(cpu_status_flags, exp);
        end
        @(posedge clk);
        bit_store_instr <= 1'b1;
        bit_src_reg <= 8'h20;
        bit_sel <= 3'h5;
        @(posedge clk);
        bit_store_instr <= 1'b0;
        bit_load_instr <= 1'b1;
        bit_src_reg <= 8'h00;
        bit_sel <= 3'h2;
        @(posedge clk);
        bit_load_instr <= 1'b0;
        #1;
        check(bit_load_data, 8'h04);
        issue(3'h1, 8'h08);
        quiet(20);
        issue(3'h2, 8'h00);
        wait_for(4, n);
        @(posedge clk);
        #1;
        check(cpu_status_flags[7], 1'b0);
        irq_local_en <= 8'hff;
        quiet(10);
        issue(3'h1, 8'h00);
        wait_for(3, n);
        wait_for(0, n);
        check(n, 2);
        check(irq_ack_id, 3'h3);
        check(prev_done, 1'b1);
        check(push_pc, 16'h0abc);
        wait_for(1, n);
        check(n, 4);
        check(in_handler, 1'b1);
        check(pc_load_value, 16'h0006);
        check(sp_out, 16'hfffe);
        check(cpu_status_flags[7], 1'b0);
        repeat (3) begin
            check(core_stall, 1'b1);
            @(posedge clk);
            #1;
        end
        check(core_stall, 1'b0);
        reg_rd(ADDR_SEQ_STATUS, 8'h0b);
        reg_rd(ADDR_IRQ_VECTOR, 8'h03);
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                issue(3'h0, k == 1 ? 8'h20 : 8'h02);
                if (k == 2) quiet(10);
                startup_done <= k == 2;
                wait_for(0, n);
                if (k == 2) check(n, 5);
                check(prev_done | sleeping, 1'b1);
                wait_for(1, n);
                check(n, 4);
                sleeping <= 1'b0;
            end
            issue(3'h4, 8'h00);
            wait_for(2, n);
            wait_for(1, n);
            check(n, 5);
            check(pc_load_value, stack_top);
            check(cpu_status_flags[7], 1'b1);
            check(sp_out, 16'h0000);
            check(in_handler, 1'b0);
            multi <= k == 0;
            sleeping <= k == 1;
        end
        close_out;
    end
endmodule // irq_entry_flags_tb
`default_nettype wire
